// file: fmc_cfg.svh
// Purpose: Named constants of the frequency meter core.
// Assumes: 20 MHz system clock, 32-bit classic bus.
// Notes: Times are kept in their own units; cycle counts derive below.
`ifndef FMC_CFG_SVH
`define FMC_CFG_SVH

`define FMC_CLK_HZ 20000000
`define FMC_NS_PER_CLK (1000000000 / `FMC_CLK_HZ)
`define FMC_CLK_PER_MS (`FMC_CLK_HZ / 1000)
// Least times round up to whole cycles
`define FMC_NS2CYC(ns) (((ns) + `FMC_NS_PER_CLK - 1) / `FMC_NS_PER_CLK)

// Debounce times, ns
`define FMC_DEB_T1_NS 500
`define FMC_DEB_T2_NS 1000
`define FMC_DEB_T3_NS 2000
`define FMC_DEB_T4_NS 5000
`define FMC_DEB_T5_NS 10000
`define FMC_DEB_T6_NS 50000
`define FMC_DEB_T7_NS 100000
`define FMC_DEB_T8_NS 250000
`define FMC_DEB_T9_NS 500000
`define FMC_DEB_T10_NS 1000000
`define FMC_DEB_T11_NS 2000000
`define FMC_DEB_T12_NS 4000000
`define FMC_DEB_T13_NS 12000000

// Sampling windows, ms
`define FMC_WIN0_MS 17'h0000a
`define FMC_WIN1_MS 17'h00064
`define FMC_WIN2_MS 17'h003e8
`define FMC_WIN3_MS 17'h0ea60

// Register byte offsets
`define FMC_OFS_FREQ 8'h00
`define FMC_OFS_STATE 8'h04
`define FMC_OFS_CMD 8'h08
`define FMC_OFS_CFG 8'h0c

// Command word bits
`define FMC_CMD_ENABLE 0
`define FMC_CMD_FORCE_EN 7
`define FMC_CMD_PRESET 8
`define FMC_CMD_ACK 11
`define FMC_CMD_W 16

// State field bits
`define FMC_ST_RUN 0
`define FMC_ST_VALID 1
`define FMC_ST_PRESET 3

// Config register field positions
`define FMC_CFG_DEB_LSB 0
`define FMC_CFG_DEB_MSB 3
`define FMC_CFG_WIN_LSB 4
`define FMC_CFG_WIN_MSB 5
`define FMC_CFG_PRE_LSB 8
`define FMC_CFG_PRE_MSB 15
`define FMC_CFG_TRIM_LSB 16
`define FMC_CFG_TRIM_MSB 23

// Reset values
`define FMC_RST_DEB_SEL 4'h3
`define FMC_RST_WIN_SEL 2'h2
`define FMC_RST_PRESCALE 8'h01
`define FMC_RST_TRIM 8'h00
`define FMC_RST_CMD 16'h0000

// Trim arithmetic, tenths of a percent
`define FMC_TRIM_UNITY 11'h3e8
`define FMC_TRIM_MAX 8'h64
`define FMC_TRIM_MIN 8'h9c
`define FMC_CENTI 7'h64
`define FMC_MIN_EDGES 2'h2

`endif

// file: fmc_pkg.sv
// Purpose: Types shared by the frequency meter core files.
// Assumes: Constants come from fmc_cfg.svh.
// Notes: None.
package fmc_pkg;

	typedef enum logic [1:0] {
		FMC_WIN_10MS = 2'b00,
		FMC_WIN_100MS = 2'b01,
		FMC_WIN_1S = 2'b10,
		FMC_WIN_60S = 2'b11
	} fmc_win_t;

	typedef enum logic [1:0] {
		FMC_ST_OFF = 2'b00,
		FMC_ST_COUNT = 2'b01,
		FMC_ST_DIVIDE = 2'b10
	} fmc_meas_t;

	typedef struct packed {
		logic [7:0] trim;
		logic [7:0] prescale;
		fmc_win_t win_sel;
		logic [3:0] deb_sel;
	} fmc_config_t;

	typedef struct packed {
		logic [31:0] measured_frequency;
		logic [7:0] function_state;
	} fmc_result_t;

endpackage

// file: fmc_debounce.sv
// Purpose: Debounce filter for the enable input.
// Assumes: Input synchronous to clk_i.
// Notes: A limit of zero passes the input straight through.
module fmc_debounce (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Filter
	input wire logic [31:0] limit_i,
	input wire logic raw_i,
	output logic filt_o
);
	logic stable_reg;
	logic [31:0] cnt_reg;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			stable_reg <= 1'b0;
			cnt_reg <= 32'h0;
		end else if (ce_i) begin
			if (raw_i == stable_reg) begin
				cnt_reg <= 32'h0;
			end else if (cnt_reg + 32'h1 >= limit_i) begin
				stable_reg <= raw_i;
				cnt_reg <= 32'h0;
			end else begin
				cnt_reg <= cnt_reg + 32'h1;
			end
		end
	end

	// Level must hold for the whole limit before it is believed
	assign filt_o = (limit_i == 32'h0) ? raw_i : stable_reg;
endmodule

// file: fmc_divider.sv
// Purpose: Sequential restoring divider, one quotient bit per cycle.
// Assumes: Denominator is never zero.
// Notes: Takes NW cycles; done_o pulses one cycle with the result.
module fmc_divider #(
	parameter int NW = 64,
	parameter int DW = 32
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Operands
	input wire logic start_i,
	input wire logic [NW-1:0] num_i,
	input wire logic [DW-1:0] den_i,
	// Result
	output logic busy_o,
	output logic done_o,
	output logic [NW-1:0] quo_o
);
	logic [DW:0] rem_reg;
	logic [DW-1:0] den_reg;
	logic [$clog2(NW+1)-1:0] cnt_reg;
	logic [DW:0] rem_sh;

	assign rem_sh = {rem_reg[DW-1:0], quo_o[NW-1]};

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rem_reg <= '0;
			den_reg <= '0;
			cnt_reg <= '0;
			quo_o <= '0;
			busy_o <= 1'b0;
			done_o <= 1'b0;
		end else if (ce_i) begin
			done_o <= 1'b0;
			if (start_i && !busy_o) begin
				rem_reg <= '0;
				den_reg <= den_i;
				quo_o <= num_i;
				cnt_reg <= '0;
				busy_o <= 1'b1;
			end else if (busy_o) begin
				if (rem_sh >= {1'b0, den_reg}) begin
					rem_reg <= rem_sh - {1'b0, den_reg};
					quo_o <= {quo_o[NW-2:0], 1'b1};
				end else begin
					rem_reg <= rem_sh;
					quo_o <= {quo_o[NW-2:0], 1'b0};
				end
				cnt_reg <= cnt_reg + 1'b1;
				if (cnt_reg == ($clog2(NW+1))'(NW - 1)) begin
					busy_o <= 1'b0;
					done_o <= 1'b1;
				end
			end
		end
	end
endmodule

// file: fmc_core.sv
// Purpose: Frequency meter core with a classic Wishbone register slave.
// Assumes: Pulse and enable inputs synchronous to clk_i.
// Notes: Result is refreshed at each window end; bus reads see it live.
// How it works
// - Enable input debounced; filter time selectable, none to 12 ms, 0.002 ms at reset.
// - Result multiplied by signed trim, 90.0 to 110 percent in 0.1 steps.
// - Pulse prescale applied first, trim correction afterwards.
// - Window 10, 100, 1000 or 60000 ms; 1000 ms at reset.
// - Valid cleared when window is under two signal periods.
// - Window may change while running; takes effect on preset rising edge.
// - Frequency is 32-bit unsigned, hundredths of a hertz.
// - Reported frequency readable toward the controller every bus cycle.
// - State bit 0 mirrors the enable condition.
// - State bit 1 set only when in range, running and window long enough.
// - State bit 3 set on each rising edge of force preset.
// - State bit 3 cleared on rising edge of preset acknowledge.
// - All other state bits reserved, read as zero.
// - Force preset, command bit 8, restarts the window timer on rising edge.
// - Preset acknowledge is command bit 11, acted on at rising edge.
// - Command bit 7 forces the enable condition true.
// - Prescale 1 to 255 input pulses per count step.
//
// Design decisions made here: the register offsets and the Wishbone slave port.
`include "fmc_cfg.svh"

module fmc_core #(
	parameter int DEB_T8_CYC = `FMC_NS2CYC(`FMC_DEB_T8_NS),
	parameter int DEB_T9_CYC = `FMC_NS2CYC(`FMC_DEB_T9_NS),
	parameter int DEB_T10_CYC = `FMC_NS2CYC(`FMC_DEB_T10_NS),
	parameter int DEB_T11_CYC = `FMC_NS2CYC(`FMC_DEB_T11_NS),
	parameter int DEB_T12_CYC = `FMC_NS2CYC(`FMC_DEB_T12_NS),
	parameter int DEB_T13_CYC = `FMC_NS2CYC(`FMC_DEB_T13_NS),
	parameter int WIN0_CYC = `FMC_WIN0_MS * `FMC_CLK_PER_MS,
	parameter int WIN1_CYC = `FMC_WIN1_MS * `FMC_CLK_PER_MS,
	parameter int WIN2_CYC = `FMC_WIN2_MS * `FMC_CLK_PER_MS,
	parameter int WIN3_CYC = `FMC_WIN3_MS * `FMC_CLK_PER_MS
) (
	// Clock, reset, enable
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// Field inputs
	input wire logic pulse_a_i,
	input wire logic gate_en_i,
	// Cyclic result
	output fmc_pkg::fmc_result_t result_o
);
	import fmc_pkg::*;

	localparam int DEB_T1_CYC = `FMC_NS2CYC(`FMC_DEB_T1_NS);
	localparam int DEB_T2_CYC = `FMC_NS2CYC(`FMC_DEB_T2_NS);
	localparam int DEB_T3_CYC = `FMC_NS2CYC(`FMC_DEB_T3_NS);
	localparam int DEB_T4_CYC = `FMC_NS2CYC(`FMC_DEB_T4_NS);
	localparam int DEB_T5_CYC = `FMC_NS2CYC(`FMC_DEB_T5_NS);
	localparam int DEB_T6_CYC = `FMC_NS2CYC(`FMC_DEB_T6_NS);
	localparam int DEB_T7_CYC = `FMC_NS2CYC(`FMC_DEB_T7_NS);

	fmc_config_t cfg_reg;
	logic [`FMC_CMD_W-1:0] cmd_reg;
	fmc_win_t win_act_reg;
	fmc_meas_t meas_reg;
	logic [31:0] timer_reg;
	logic [7:0] pre_cnt_reg;
	logic [31:0] pulse_cnt_reg;
	logic [1:0] edge_cnt_reg;
	logic a_prev_reg;
	logic preset_prev_reg;
	logic ack_prev_reg;
	logic preset_flag_reg;
	logic [31:0] freq_reg;
	logic valid_reg;
	logic [31:0] snap_cnt_reg;
	logic snap_long_reg;
	logic [7:0] trim_snap_reg;
	fmc_win_t win_snap_reg;
	logic div_start;
	logic div_busy;
	logic div_done;
	logic [63:0] div_quo;
	logic [63:0] div_num;
	logic [10:0] factor;
	logic en_filt;
	logic enable_cond;
	logic a_rise;
	logic preset_rise;
	logic ack_rise;
	logic window_end;
	logic bus_req;
	logic [7:0] state_byte;
	logic [31:0] wr_cfg;

	// Debounce limit for each filter choice
	function automatic logic [31:0] deb_limit(input logic [3:0] sel);
		case (sel)
			4'h0: deb_limit = 32'h0;
			4'h1: deb_limit = 32'(DEB_T1_CYC);
			4'h2: deb_limit = 32'(DEB_T2_CYC);
			4'h3: deb_limit = 32'(DEB_T3_CYC);
			4'h4: deb_limit = 32'(DEB_T4_CYC);
			4'h5: deb_limit = 32'(DEB_T5_CYC);
			4'h6: deb_limit = 32'(DEB_T6_CYC);
			4'h7: deb_limit = 32'(DEB_T7_CYC);
			4'h8: deb_limit = 32'(DEB_T8_CYC);
			4'h9: deb_limit = 32'(DEB_T9_CYC);
			4'ha: deb_limit = 32'(DEB_T10_CYC);
			4'hb: deb_limit = 32'(DEB_T11_CYC);
			4'hc: deb_limit = 32'(DEB_T12_CYC);
			default: deb_limit = 32'(DEB_T13_CYC);
		endcase
	endfunction

	function automatic logic [31:0] win_cycles(input fmc_win_t sel);
		case (sel)
			FMC_WIN_10MS: win_cycles = 32'(WIN0_CYC);
			FMC_WIN_100MS: win_cycles = 32'(WIN1_CYC);
			FMC_WIN_1S: win_cycles = 32'(WIN2_CYC);
			default: win_cycles = 32'(WIN3_CYC);
		endcase
	endfunction

	function automatic logic [16:0] win_ms(input fmc_win_t sel);
		case (sel)
			FMC_WIN_10MS: win_ms = `FMC_WIN0_MS;
			FMC_WIN_100MS: win_ms = `FMC_WIN1_MS;
			FMC_WIN_1S: win_ms = `FMC_WIN2_MS;
			default: win_ms = `FMC_WIN3_MS;
		endcase
	endfunction

	function automatic logic [7:0] clamp_trim(input logic [7:0] t);
		if (!t[7] && t > `FMC_TRIM_MAX) begin
			clamp_trim = `FMC_TRIM_MAX;
		end else if (t[7] && t < `FMC_TRIM_MIN) begin
			clamp_trim = `FMC_TRIM_MIN;
		end else begin
			clamp_trim = t;
		end
	endfunction

	fmc_debounce u_debounce (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.limit_i(deb_limit(cfg_reg.deb_sel)),
		.raw_i(gate_en_i),
		.filt_o(en_filt)
	);

	// Enable condition: software force or gated input
	assign enable_cond = cmd_reg[`FMC_CMD_FORCE_EN]
		| (cmd_reg[`FMC_CMD_ENABLE] & en_filt);
	assign a_rise = pulse_a_i & ~a_prev_reg;
	assign preset_rise = cmd_reg[`FMC_CMD_PRESET] & ~preset_prev_reg;
	assign ack_rise = cmd_reg[`FMC_CMD_ACK] & ~ack_prev_reg;
	assign window_end = (meas_reg == FMC_ST_COUNT)
		&& (timer_reg + 32'h1 >= win_cycles(win_act_reg));

	// Wishbone register slave
	assign bus_req = cyc_i & stb_i & ~ack_o;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
		end else if (ce_i) begin
			ack_o <= bus_req;
		end
	end

	always_comb begin
		wr_cfg = {8'h0, cfg_reg.trim, cfg_reg.prescale, 2'h0,
			cfg_reg.win_sel, cfg_reg.deb_sel};
		for (int i = 0; i < 4; i++) begin
			if (sel_i[i]) begin
				wr_cfg[i*8 +: 8] = dat_i[i*8 +: 8];
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cfg_reg.deb_sel <= `FMC_RST_DEB_SEL;
			cfg_reg.win_sel <= fmc_win_t'(`FMC_RST_WIN_SEL);
			cfg_reg.prescale <= `FMC_RST_PRESCALE;
			cfg_reg.trim <= `FMC_RST_TRIM;
		end else if (ce_i && bus_req && we_i && adr_i == `FMC_OFS_CFG) begin
			cfg_reg.deb_sel <= wr_cfg[`FMC_CFG_DEB_MSB:`FMC_CFG_DEB_LSB];
			cfg_reg.win_sel <=
				fmc_win_t'(wr_cfg[`FMC_CFG_WIN_MSB:`FMC_CFG_WIN_LSB]);
			// Zero would stall counting, so it is taken as one
			cfg_reg.prescale <=
				(wr_cfg[`FMC_CFG_PRE_MSB:`FMC_CFG_PRE_LSB] == 8'h0) ?
				8'h01 : wr_cfg[`FMC_CFG_PRE_MSB:`FMC_CFG_PRE_LSB];
			cfg_reg.trim <=
				clamp_trim(wr_cfg[`FMC_CFG_TRIM_MSB:`FMC_CFG_TRIM_LSB]);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cmd_reg <= `FMC_RST_CMD;
		end else if (ce_i && bus_req && we_i && adr_i == `FMC_OFS_CMD) begin
			if (sel_i[0]) begin
				cmd_reg[7:0] <= dat_i[7:0];
			end
			if (sel_i[1]) begin
				cmd_reg[15:8] <= dat_i[15:8];
			end
		end
	end

	// Reserved state bits stay zero
	always_comb begin
		state_byte = 8'h0;
		state_byte[`FMC_ST_RUN] = enable_cond;
		state_byte[`FMC_ST_VALID] = valid_reg & enable_cond;
		state_byte[`FMC_ST_PRESET] = preset_flag_reg;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_o <= 32'h0;
		end else if (ce_i && bus_req && !we_i) begin
			if (adr_i == `FMC_OFS_FREQ) begin
				dat_o <= freq_reg;
			end else if (adr_i == `FMC_OFS_STATE) begin
				dat_o <= {24'h0, state_byte};
			end else if (adr_i == `FMC_OFS_CMD) begin
				dat_o <= {16'h0, cmd_reg};
			end else if (adr_i == `FMC_OFS_CFG) begin
				dat_o <= {8'h0, cfg_reg.trim, cfg_reg.prescale, 2'h0,
					cfg_reg.win_sel, cfg_reg.deb_sel};
			end else begin
				dat_o <= 32'h0;
			end
		end
	end

	// Edge history of command bits and pulse input
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			a_prev_reg <= 1'b0;
			preset_prev_reg <= 1'b0;
			ack_prev_reg <= 1'b0;
		end else if (ce_i) begin
			a_prev_reg <= pulse_a_i;
			preset_prev_reg <= cmd_reg[`FMC_CMD_PRESET];
			ack_prev_reg <= cmd_reg[`FMC_CMD_ACK];
		end
	end

	// Set wins over acknowledge in the same cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			preset_flag_reg <= 1'b0;
		end else if (ce_i) begin
			if (preset_rise) begin
				preset_flag_reg <= 1'b1;
			end else if (ack_rise) begin
				preset_flag_reg <= 1'b0;
			end
		end
	end

	// Online window change is deferred to the preset edge
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			win_act_reg <= fmc_win_t'(`FMC_RST_WIN_SEL);
		end else if (ce_i && preset_rise) begin
			win_act_reg <= cfg_reg.win_sel;
		end
	end

	// Measurement sequencing
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meas_reg <= FMC_ST_OFF;
		end else if (ce_i) begin
			case (meas_reg)
				FMC_ST_OFF: begin
					if (enable_cond) begin
						meas_reg <= FMC_ST_COUNT;
					end
				end
				FMC_ST_COUNT: begin
					if (!enable_cond) begin
						meas_reg <= FMC_ST_OFF;
					end else if (window_end && div_busy) begin
						meas_reg <= FMC_ST_DIVIDE;
					end
				end
				FMC_ST_DIVIDE: begin
					if (!enable_cond) begin
						meas_reg <= FMC_ST_OFF;
					end else if (!div_busy) begin
						meas_reg <= FMC_ST_COUNT;
					end
				end
				default: meas_reg <= FMC_ST_OFF;
			endcase
		end
	end

	// Window timer and prescaled pulse counter
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			timer_reg <= 32'h0;
			pre_cnt_reg <= 8'h0;
			pulse_cnt_reg <= 32'h0;
			edge_cnt_reg <= 2'h0;
		end else if (ce_i) begin
			if (!enable_cond || meas_reg == FMC_ST_OFF || preset_rise
				|| window_end) begin
				timer_reg <= 32'h0;
				pre_cnt_reg <= 8'h0;
				pulse_cnt_reg <= 32'h0;
				edge_cnt_reg <= 2'h0;
			end else begin
				timer_reg <= timer_reg + 32'h1;
				if (a_rise) begin
					if (edge_cnt_reg != `FMC_MIN_EDGES) begin
						edge_cnt_reg <= edge_cnt_reg + 2'h1;
					end
					if (pre_cnt_reg + 8'h1 >= cfg_reg.prescale) begin
						pre_cnt_reg <= 8'h0;
						pulse_cnt_reg <= pulse_cnt_reg + 32'h1;
					end else begin
						pre_cnt_reg <= pre_cnt_reg + 8'h1;
					end
				end
			end
		end
	end

	// Snapshot of the closing window for the divider
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			snap_cnt_reg <= 32'h0;
			snap_long_reg <= 1'b0;
			trim_snap_reg <= 8'h0;
			win_snap_reg <= fmc_win_t'(`FMC_RST_WIN_SEL);
		end else if (ce_i && window_end && !div_busy) begin
			snap_cnt_reg <= pulse_cnt_reg;
			// Under two edges means window below two periods
			snap_long_reg <= (edge_cnt_reg == `FMC_MIN_EDGES);
			trim_snap_reg <= cfg_reg.trim;
			win_snap_reg <= win_act_reg;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			div_start <= 1'b0;
		end else if (ce_i) begin
			div_start <= window_end && !div_busy;
		end
	end

	// Count is already prescaled; trim scales the quotient numerator
	assign factor = `FMC_TRIM_UNITY
		+ {{3{trim_snap_reg[7]}}, trim_snap_reg};
	assign div_num = 64'(snap_cnt_reg) * 64'(`FMC_CENTI)
		* 64'(factor);

	fmc_divider #(
		.NW(64),
		.DW(32)
	) u_divider (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.start_i(div_start),
		.num_i(div_num),
		.den_i(32'(win_ms(win_snap_reg))),
		.busy_o(div_busy),
		.done_o(div_done),
		.quo_o(div_quo)
	);

	// Result latch; out-of-range saturates and reads as not valid
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			freq_reg <= 32'h0;
			valid_reg <= 1'b0;
		end else if (ce_i) begin
			if (!enable_cond) begin
				valid_reg <= 1'b0;
			end else if (div_done) begin
				if (div_quo[63:32] != 32'h0) begin
					freq_reg <= 32'hffffffff;
					valid_reg <= 1'b0;
				end else begin
					freq_reg <= div_quo[31:0];
					valid_reg <= snap_long_reg;
				end
			end
		end
	end

	// One driver for the whole cyclic image
	assign result_o = {freq_reg, state_byte};
endmodule

// file: fmc_core_properties.sv
// Purpose: Port-level checks on the frequency meter core.
// Assumes: Command word tracked from bus writes, byte lanes 0 and 1.
// Notes: Bound to every fmc_core instance.
module fmc_core_checker (
	// Clock, reset, enable
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Bus
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	input wire logic [31:0] dat_o,
	input wire logic ack_o,
	// Field and result
	input wire logic pulse_a_i,
	input wire logic gate_en_i,
	input wire fmc_pkg::fmc_result_t result_o
);
	timeunit 1ns;
	timeprecision 1ns;
	import fmc_pkg::*;
	logic [15:0] cmd_h;
	logic take;
	logic [7:0] st;
	assign take = cyc_i && stb_i && !ack_o && ce_i;
	assign st = result_o.function_state;
	always_ff @(posedge clk_i) begin
		if (rst_i)
			cmd_h <= 16'h0000;
		else if (take && we_i && adr_i == 8'h08) begin
			if (sel_i[0])
				cmd_h[7:0] <= dat_i[7:0];
			if (sel_i[1])
				cmd_h[15:8] <= dat_i[15:8];
		end
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	property p_ack_resp; take |=> ack_o; endproperty
	a_ack_resp: assert property (p_ack_resp)
		else $error("request not acknowledged");
	property p_ack_pulse; ack_o && ce_i |=> !ack_o; endproperty
	a_ack_pulse: assert property (p_ack_pulse)
		else $error("acknowledge held");
	property p_rd_freq;
		take && !we_i && adr_i == 8'h00 |=>
			dat_o == $past(result_o.measured_frequency);
	endproperty
	a_rd_freq: assert property (p_rd_freq)
		else $error("frequency read differs");
	property p_rd_state;
		take && !we_i && adr_i == 8'h04 |=> dat_o == {24'h0, $past(st)};
	endproperty
	a_rd_state: assert property (p_rd_state)
		else $error("state read differs");
	property p_rd_unmap;
		take && !we_i && adr_i[7:4] != 4'h0 |=> dat_o == 32'h0;
	endproperty
	a_rd_unmap: assert property (p_rd_unmap)
		else $error("unmapped read not zero");
	property p_reserved; st[7:4] == 4'h0 && !st[2]; endproperty
	a_reserved: assert property (p_reserved)
		else $error("reserved state bit set");
	property p_valid_run; !st[0] && ce_i |=> !st[1]; endproperty
	a_valid_run: assert property (p_valid_run)
		else $error("valid kept after stop");
	property p_freeze;
		!ce_i |=> $stable(result_o.measured_frequency) && $stable(dat_o);
	endproperty
	a_freeze: assert property (p_freeze)
		else $error("state moved while clock enable low");
	property p_force; cmd_h[7] && $past(cmd_h[7]) |-> st[0]; endproperty
	a_force: assert property (p_force)
		else $error("forced enable not running");
	property p_preset_set; $rose(cmd_h[8]) && ce_i |-> ##[0:2] st[3];
	endproperty
	a_preset_set: assert property (p_preset_set)
		else $error("preset flag not set");
	property p_preset_ack;
		$rose(cmd_h[11]) && !$rose(cmd_h[8]) && ce_i |-> ##[0:2] !st[3];
	endproperty
	a_preset_ack: assert property (p_preset_ack)
		else $error("preset flag not cleared");
	cover property (take && !we_i && adr_i == 8'h00);
	cover property ($rose(st[1]));
	cover property ($rose(st[3]));
endmodule

bind fmc_core fmc_core_checker i_fmc_core_checker (.clk_i(clk_i),
	.rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
	.adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
	.ack_o(ack_o), .pulse_a_i(pulse_a_i), .gate_en_i(gate_en_i),
	.result_o(result_o));

// file: fmc_field_src.sv
// Purpose: Pulse source and bouncing enable contact.
// Assumes: Period in clock cycles; zero stops the pulses.
// Notes: Each enable change bounces for six cycles.
module fmc_field_src (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Control
	input wire logic [15:0] period_i,
	input wire logic gate_i,
	// Field lines
	output logic pulse_o,
	output logic gate_o
);
	timeunit 1ns;
	timeprecision 1ns;
	int ph = 0;
	int bn = 0;
	logic last = 1'b0;
	initial begin
		pulse_o = 1'b0;
		gate_o = 1'b0;
	end
	always @(posedge clk_i) begin
		if (rst_i || period_i == 16'h0000) begin
			ph <= 0;
			pulse_o <= 1'b0;
		end else begin
			ph <= (ph + 1 >= period_i) ? 0 : ph + 1;
			pulse_o <= (ph < period_i / 2);
		end
	end
	// Contact chatter, shorter than the reset filter time
	always @(posedge clk_i) begin
		last <= gate_i;
		if (gate_i != last)
			bn <= 6;
		else if (bn > 0)
			bn <= bn - 1;
		gate_o <= (bn > 0) ? ~gate_o : gate_i;
	end
endmodule

// file: fmc_core_test.sv
// Purpose: Self-checking bench of the frequency meter core.
// Assumes: Windows shortened to 200, 400, 800 and 1600 cycles.
// Notes: Pulse phase is free, so a count may be off by one.
module fmc_core_test;
	timeunit 1ns;
	timeprecision 1ns;
	import fmc_pkg::*;
	localparam int WC [4] = '{200, 400, 800, 1600};
	localparam int WMS [4] = '{10, 100, 1000, 60000};
	logic clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1;
	logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, gate_raw = 1'b0;
	logic [7:0] adr_i = 8'h00;
	logic [3:0] sel_i = 4'h0;
	logic [31:0] dat_i = 32'h0, dat_o, rd;
	logic [15:0] period = 16'h0000;
	logic ack_o, pulse_a_i, gate_en_i;
	logic [31:0] seed = 32'h00005ebd;
	fmc_result_t result_o;
	int err_total = 0;
	int n_compared = 0;
	always #25 clk_i = ~clk_i;
	fmc_core #(.WIN0_CYC(200), .WIN1_CYC(400), .WIN2_CYC(800),
		.WIN3_CYC(1600)) i_fmc_core (.clk_i(clk_i), .rst_i(rst_i),
		.ce_i(ce_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
		.adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
		.ack_o(ack_o), .pulse_a_i(pulse_a_i), .gate_en_i(gate_en_i),
		.result_o(result_o));
	fmc_field_src i_fmc_field_src (.clk_i(clk_i), .rst_i(rst_i),
		.period_i(period), .gate_i(gate_raw), .pulse_o(pulse_a_i),
		.gate_o(gate_en_i));
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic end_sim();
		if (err_total == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] exp, got);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		sel_i <= {4{w}};
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 20);
		if (n >= 20) begin
			err_total++;
			end_sim();
		end
		rd = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
	endtask
	// Model: count = edges / prescale, value = count*100*(1000+trim)/ms
	task automatic meas(input int w, pre, tr, per);
		longint e, best, b2;
		logic [31:0] live;
		wt(2 * WC[w] + 150);
		wb(1'b0, 8'h00, 32'h0);
		live = result_o.measured_frequency;
		e = WC[w] / per;
		best = (e / pre) * 100 * (1000 + tr) / WMS[w];
		b2 = best;
		for (longint c = (e - 1) / pre; c <= (e + 1) / pre; c++) begin
			if (rd === 32'(c * 100 * (1000 + tr) / WMS[w]))
				best = c * 100 * (1000 + tr) / WMS[w];
			if (live === 32'(c * 100 * (1000 + tr) / WMS[w]))
				b2 = c * 100 * (1000 + tr) / WMS[w];
		end
		chk("frequency", 32'(best), rd);
		chk("cyclic frequency", 32'(b2), live);
		chk("valid", 32'h1, 32'(result_o.function_state[1]));
	endtask
	initial begin
		int w, pre, tr, per;
		wt(20);
		rst_i <= 1'b0;
		wb(1'b0, 8'h0c, 32'h0);
		chk("config", 32'h00000123, rd);
		wb(1'b0, 8'h40, 32'h0);
		chk("unmapped", 32'h0, rd);
		wb(1'b1, 8'h04, 32'h000000ff);
		wb(1'b0, 8'h04, 32'h0);
		chk("state", 32'h0, rd);
		wb(1'b1, 8'h08, 32'h00000001);
		gate_raw <= 1'b1;
		period <= 16'h000a;
		wt(30);
		chk("run early", 32'h0, 32'(result_o.function_state[0]));
		wt(70);
		chk("run", 32'h1, 32'(result_o.function_state[0]));
		meas(2, 1, 0, 10);
		gate_raw <= 1'b0;
		wt(100);
		chk("stopped", 32'h0, 32'(result_o.function_state));
		wb(1'b1, 8'h08, 32'h00000080);
		chk("forced", 32'h1, 32'(result_o.function_state[0]));
		for (int i = 0; i < 8; i++) begin
			w = i % 4;
			pre = rnd() % 5 + 1;
			tr = int'(rnd() % 201) - 100;
			per = 4 + rnd() % (WC[w] / 16);
			ce_i <= 1'b0;
			wt(3);
			ce_i <= 1'b1;
			period <= 16'(per);
			wb(1'b1, 8'h0c, {8'h00, 8'(tr), 8'(pre), 2'b00, 2'(w), 4'h3});
			wb(1'b1, 8'h08, 32'h00000180);
			wt(2);
			chk("preset", 32'h1, 32'(result_o.function_state[3]));
			wb(1'b1, 8'h08, 32'h00000980);
			wt(2);
			chk("ack", 32'h0, 32'(result_o.function_state[3]));
			wb(1'b1, 8'h08, 32'h00000080);
			meas(w, pre, tr, per);
		end
		period <= 16'd300;
		wb(1'b1, 8'h0c, 32'h00000103);
		wb(1'b1, 8'h08, 32'h00000180);
		wt(550);
		chk("short window", 32'h0, 32'(result_o.function_state[1]));
		// New window written without preset must not take over
		period <= 16'h000a;
		wb(1'b1, 8'h0c, 32'h00000013);
		wb(1'b0, 8'h0c, 32'h0);
		chk("zero prescale", 32'h00000113, rd);
		meas(0, 1, 0, 10);
		end_sim();
	end
	initial begin
		wt(100000);
		err_total++;
		end_sim();
	end
endmodule
